// ==== src/dpc_pkg.sv ====
package dpc_pkg;

   localparam int DPC_ROW_W = 16;
   localparam int DPC_COL_W = 10;
   localparam int DPC_BANK_W = 3;
   localparam int DPC_NUM_BANKS = 8;
   localparam int DPC_NUM_MR = 4;

   // address bit positions with a fixed meaning
   localparam int DPC_AP_BIT = 10;
   localparam int DPC_BC_BIT = 12;

   // mode register fields
   localparam int DPC_MR0_BL_LO = 0;
   localparam logic [1:0] DPC_BL_OTF = 2'h1;
   localparam int DPC_MR1_RTT_B0 = 2;
   localparam int DPC_MR1_RTT_B1 = 6;
   localparam int DPC_MR1_RTT_B2 = 9;
   localparam int DPC_MR1_TDQS_BIT = 11;
   localparam int DPC_MR2_RTTWR_LO = 9;
   localparam logic [15:0] DPC_MR_RESET = 16'h0000;

   localparam logic [3:0] DPC_BEATS_BL8 = 4'h8;
   localparam logic [3:0] DPC_BEATS_BC4 = 4'h4;

   // {cs_n, ras_n, cas_n, we_n}
   typedef enum logic [3:0] {
      DPC_CMD_MRS = 4'b0000,
      DPC_CMD_REF = 4'b0001,
      DPC_CMD_PRE = 4'b0010,
      DPC_CMD_ACT = 4'b0011,
      DPC_CMD_WR = 4'b0100,
      DPC_CMD_RD = 4'b0101,
      DPC_CMD_ZQ = 4'b0110,
      DPC_CMD_NOP = 4'b0111
   } dpc_cmd_type;

   typedef enum logic [1:0] {
      DPC_PWR_ACTIVE = 2'b00,
      DPC_PWR_PRE_PD = 2'b01,
      DPC_PWR_ACT_PD = 2'b10,
      DPC_PWR_SELF_REF = 2'b11
   } dpc_pwr_type;

   typedef struct packed {
      logic cke;
      logic cs_n;
      logic ras_n;
      logic cas_n;
      logic we_n;
      logic [DPC_BANK_W-1:0] ba;
      logic [DPC_ROW_W-1:0] addr;
      logic odt;
   } dpc_ca_type;

   typedef struct packed {
      logic ck;
      logic cke;
      logic odt;
      logic ca;
      logic dq;
   } dpc_buf_type;

   typedef struct packed {
      logic valid;
      dpc_cmd_type kind;
      logic [DPC_BANK_W-1:0] bank;
      logic [DPC_ROW_W-1:0] row;
      logic [DPC_COL_W-1:0] col;
      logic auto_pre;
      logic all_banks;
      logic chop;
   } dpc_dec_type;

endpackage

// ==== src/dpc_pin_cmd.sv ====
// Added by the designer: strobed register access and the placing of the registers.
`timescale 1ns/1ps
// Function
// - activate takes row from address; read/write take column and auto-precharge on A10.
// - precharge with A10 low closes selected bank; A10 high closes all banks.
// - load mode presents op-code on address; device stores it in chosen register.
// - with on-the-fly chop enabled, A12 high gives BL8, low gives BC4.
// - bank address picks which of eight banks a bank command targets.
// - bank address picks which of four mode registers load mode writes.
// - all control and address sampled on rising clock; read strobe referenced to clock.
// - CKE registered high enables internal circuitry, registered low disables it.
// - CKE low gives precharge power-down or self refresh if idle, else active power-down.
// - CKE synchronous for power-down entry/exit and self-refresh entry, async for exit.
// - power-down keeps CK, CKE, RESET, ODT buffers; self refresh keeps CKE, RESET.
// - chip select low enables decoder; high masks every command.
// - command decoded from CS, RAS, CAS, WE sampled together.
// - write beat with data mask high is dropped.
// - on x8 the mask input may serve as termination data strobe.
// - ODT registered high enables termination, low disables it.
// - termination applies only to data bits, data strobes and mask.
// - when termination is disabled by load mode, ODT input is ignored.
// - reset input active low, acts asynchronously.
// - x8 mode register selects shared ball as inverted termination strobe or no function.
// - device drives read strobe edge-aligned with read data.
// - termination strobe enabled on x8 disables masking; balls give termination only.
module dpc_pin_cmd
   import dpc_pkg::*;
#(
   parameter int DQ_W = 8,
   parameter bit IS_X8 = 1'b1
) (
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic clk_en,
   input wire logic reset_n,
   input wire dpc_ca_type ca_pin,
   input wire logic [DQ_W-1:0] dq_in,
   input wire logic dqs_in,
   input wire logic dm_in,
   output logic [DQ_W-1:0] dq_out,
   output logic dq_oe_n,
   output logic dqs_out,
   output logic dqs_oe_n,
   input wire logic rd_valid,
   input wire logic [DQ_W-1:0] rd_data,
   output logic rd_ready,
   output dpc_dec_type cmd,
   output logic [DPC_NUM_BANKS-1:0] bank_open,
   output dpc_pwr_type pwr_state,
   output dpc_buf_type buf_en,
   output logic core_en,
   output logic term_dq,
   output logic term_dqs,
   output logic term_dm,
   output logic tdqs_active,
   output logic tdqs_n_active,
   output logic wr_valid,
   output logic [DQ_W-1:0] wr_data,
   output logic wr_busy
);

   ////////////////////////////////////////////////////////////////////////////////
   // pin capture: two flops, first one read only by the second

   dpc_ca_type ca_s1;
   dpc_ca_type ca_s2;
   logic [DQ_W-1:0] dq_s1;
   logic [DQ_W-1:0] dq_s2;
   logic [1:0] dqs_s1;
   logic [1:0] dqs_s2;
   logic dqs_prev;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         ca_s1 <= '0;
         ca_s2 <= '0;
         dq_s1 <= '0;
         dq_s2 <= '0;
         dqs_s1 <= '0;
         dqs_s2 <= '0;
         dqs_prev <= 1'b0;
      end else if (reset) begin
         ca_s1 <= '0;
         ca_s2 <= '0;
         dq_s1 <= '0;
         dq_s2 <= '0;
         dqs_s1 <= '0;
         dqs_s2 <= '0;
         dqs_prev <= 1'b0;
      end else if (clk_en) begin
         ca_s1 <= ca_pin;
         ca_s2 <= ca_s1;
         dq_s1 <= dq_in;
         dq_s2 <= dq_s1;
         dqs_s1 <= {dm_in, dqs_in};
         dqs_s2 <= dqs_s1;
         dqs_prev <= dqs_s2[0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // power state and input buffers

   logic cke_prev;
   logic all_idle;
   logic cmd_buf_on;
   logic [3:0] cmd_code;
   dpc_cmd_type cmd_kind;
   dpc_pwr_type next_pwr;

   assign all_idle = ~|bank_open;
   assign cmd_code = {ca_s2.cs_n, ca_s2.ras_n, ca_s2.cas_n, ca_s2.we_n};
   assign cmd_kind = dpc_cmd_type'(cmd_code);
   assign cmd_buf_on = buf_en.ca;

   always_comb begin
      next_pwr = pwr_state;
      case (pwr_state)
         DPC_PWR_ACTIVE: begin
            if (cke_prev && !ca_s2.cke) begin
               if (cmd_kind == DPC_CMD_REF && all_idle) begin
                  next_pwr = DPC_PWR_SELF_REF;
               end else if (all_idle) begin
                  next_pwr = DPC_PWR_PRE_PD;
               end else begin
                  next_pwr = DPC_PWR_ACT_PD;
               end
            end
         end
         DPC_PWR_PRE_PD, DPC_PWR_ACT_PD: begin
            if (ca_s2.cke) begin
               next_pwr = DPC_PWR_ACTIVE;
            end
         end
         DPC_PWR_SELF_REF: begin
            next_pwr = pwr_state;
         end
         default: begin
            next_pwr = DPC_PWR_ACTIVE;
         end
      endcase
   end

   // self-refresh exit looks at cke without the clock enable or a prior edge,
   // since the clock may be stopped while the device sits in self refresh
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pwr_state <= DPC_PWR_ACTIVE;
         cke_prev <= 1'b0;
      end else if (reset) begin
         pwr_state <= DPC_PWR_ACTIVE;
         cke_prev <= 1'b0;
      end else if (pwr_state == DPC_PWR_SELF_REF && ca_s2.cke) begin
         pwr_state <= DPC_PWR_ACTIVE;
         cke_prev <= 1'b1;
      end else if (clk_en) begin
         pwr_state <= next_pwr;
         cke_prev <= ca_s2.cke;
      end
   end

   assign buf_en.cke = 1'b1;
   assign buf_en.ck = pwr_state != DPC_PWR_SELF_REF;
   assign buf_en.odt = pwr_state != DPC_PWR_SELF_REF;
   assign buf_en.ca = pwr_state == DPC_PWR_ACTIVE;
   assign buf_en.dq = pwr_state == DPC_PWR_ACTIVE;
   assign core_en = pwr_state == DPC_PWR_ACTIVE && ca_s2.cke;

   ////////////////////////////////////////////////////////////////////////////////
   // command decode

   logic take;
   logic [15:0] mode_reg [DPC_NUM_MR];
   logic otf_en;
   logic tdqs_en;
   logic rtt_off;
   dpc_dec_type next_cmd;

   // a deselected rank takes no command, so a shared bus can address other ranks
   assign take = core_en && cmd_buf_on && !ca_s2.cs_n;
   assign otf_en = mode_reg[0][DPC_MR0_BL_LO +: 2] == DPC_BL_OTF;
   assign tdqs_en = IS_X8 && mode_reg[1][DPC_MR1_TDQS_BIT];
   assign rtt_off = !mode_reg[1][DPC_MR1_RTT_B0] && !mode_reg[1][DPC_MR1_RTT_B1]
      && !mode_reg[1][DPC_MR1_RTT_B2] && mode_reg[2][DPC_MR2_RTTWR_LO +: 2] == 2'h0;

   always_comb begin
      next_cmd.valid = take && cmd_kind != DPC_CMD_NOP;
      next_cmd.kind = cmd_kind;
      next_cmd.bank = ca_s2.ba;
      next_cmd.row = (cmd_kind == DPC_CMD_ACT || cmd_kind == DPC_CMD_MRS) ? ca_s2.addr
         : '0;
      next_cmd.col = ca_s2.addr[DPC_COL_W-1:0];
      next_cmd.auto_pre = (cmd_kind == DPC_CMD_RD || cmd_kind == DPC_CMD_WR)
         && ca_s2.addr[DPC_AP_BIT];
      next_cmd.all_banks = cmd_kind == DPC_CMD_PRE && ca_s2.addr[DPC_AP_BIT];
      next_cmd.chop = (cmd_kind == DPC_CMD_RD || cmd_kind == DPC_CMD_WR) && otf_en
         && !ca_s2.addr[DPC_BC_BIT];
   end

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cmd <= '0;
      end else if (reset) begin
         cmd <= '0;
      end else if (clk_en) begin
         cmd <= next_cmd;
      end
   end

   // mode registers; the op-code rides on the address pins
   genvar gm;
   generate
      for (gm = 0; gm < DPC_NUM_MR; gm++) begin : g_mr
         logic hit;
         assign hit = take && cmd_kind == DPC_CMD_MRS && ca_s2.ba[2] == 1'b0
            && ca_s2.ba[1:0] == 2'(gm);
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               mode_reg[gm] <= DPC_MR_RESET;
            end else if (reset) begin
               mode_reg[gm] <= DPC_MR_RESET;
            end else if (clk_en && hit) begin
               mode_reg[gm] <= ca_s2.addr;
            end
         end
      end
   endgenerate

   // per-bank open row tracking
   genvar gb;
   generate
      for (gb = 0; gb < DPC_NUM_BANKS; gb++) begin : g_bank
         logic sel;
         logic close;
         assign sel = ca_s2.ba == DPC_BANK_W'(gb);
         assign close = take && cmd_kind == DPC_CMD_PRE
            && (ca_s2.addr[DPC_AP_BIT] || sel);
         always_ff @(posedge clk_sys or negedge reset_n) begin
            if (!reset_n) begin
               bank_open[gb] <= 1'b0;
            end else if (reset) begin
               bank_open[gb] <= 1'b0;
            end else if (clk_en) begin
               if (take && cmd_kind == DPC_CMD_ACT && sel) begin
                  bank_open[gb] <= 1'b1;
               end else if (close) begin
                  bank_open[gb] <= 1'b0;
               end else if (take && sel && ca_s2.addr[DPC_AP_BIT]
                  && (cmd_kind == DPC_CMD_RD || cmd_kind == DPC_CMD_WR)) begin
                  bank_open[gb] <= 1'b0;
               end
            end
         end
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // termination

   logic odt_reg;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         odt_reg <= 1'b0;
      end else if (reset) begin
         odt_reg <= 1'b0;
      end else if (clk_en) begin
         odt_reg <= buf_en.odt && ca_s2.odt && !rtt_off;
      end
   end

   assign term_dq = odt_reg;
   assign term_dqs = odt_reg;
   assign term_dm = odt_reg;
   assign tdqs_active = tdqs_en;
   assign tdqs_n_active = tdqs_en;

   ////////////////////////////////////////////////////////////////////////////////
   // write beats: one beat per strobe edge after a write, masked by dm

   logic [3:0] wr_left;
   logic wr_edge;

   assign wr_edge = dqs_s2[0] != dqs_prev;
   assign wr_busy = wr_left != 4'h0;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         wr_left <= 4'h0;
         wr_valid <= 1'b0;
         wr_data <= '0;
      end else if (reset) begin
         wr_left <= 4'h0;
         wr_valid <= 1'b0;
         wr_data <= '0;
      end else if (clk_en) begin
         wr_valid <= 1'b0;
         if (take && cmd_kind == DPC_CMD_WR) begin
            wr_left <= next_cmd.chop ? DPC_BEATS_BC4 : DPC_BEATS_BL8;
         end else if (wr_busy && wr_edge) begin
            wr_left <= wr_left - 4'h1;
            // mask lane is a termination strobe when tdqs is on, so never masks
            wr_valid <= tdqs_en || !dqs_s2[1];
            wr_data <= dq_s2;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // read beats: strobe toggles in the same flop stage as data

   assign rd_ready = buf_en.dq;

   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         dq_out <= '0;
         dqs_out <= 1'b0;
         dq_oe_n <= 1'b1;
         dqs_oe_n <= 1'b1;
      end else if (reset) begin
         dq_out <= '0;
         dqs_out <= 1'b0;
         dq_oe_n <= 1'b1;
         dqs_oe_n <= 1'b1;
      end else if (clk_en) begin
         dq_oe_n <= !(rd_valid && rd_ready);
         dqs_oe_n <= !(rd_valid && rd_ready);
         if (rd_valid && rd_ready) begin
            dq_out <= rd_data;
            dqs_out <= !dqs_out;
         end
      end
   end

endmodule

// ==== sim/dpc_pin_cmd_chk.sv ====
`timescale 1ns/1ps
module dpc_pin_cmd_chk
   import dpc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic reset_n,
   input wire dpc_ca_type ca_pin,
   input wire dpc_dec_type cmd,
   input wire logic [DPC_NUM_BANKS-1:0] bank_open,
   input wire dpc_pwr_type pwr_state,
   input wire dpc_buf_type buf_en,
   input wire logic core_en,
   input wire logic rd_ready
);
   default clocking @(posedge clk_sys); endclocking
   // the pin reset clears the sync pipeline too, so it masks the checks
   default disable iff (reset || !reset_n);
   sequence s_go(k);
      cmd.valid && cmd.kind == k;
   endsequence
   sequence s_rw;
      s_go(DPC_CMD_RD) or s_go(DPC_CMD_WR);
   endsequence
   property p_cs;
      cmd.valid |-> !$past(ca_pin.cs_n, 3);
   endproperty
   a_cs: assert property (p_cs) else $error("command taken while deselected");
   property p_kind;
      cmd.valid |-> cmd.kind == $past({ca_pin.cs_n, ca_pin.ras_n, ca_pin.cas_n, ca_pin.we_n}, 3);
   endproperty
   a_kind: assert property (p_kind) else $error("wrong command kind");
   property p_row;
      s_go(DPC_CMD_ACT) |-> cmd.row == $past(ca_pin.addr, 3) && cmd.bank == $past(ca_pin.ba, 3);
   endproperty
   a_row: assert property (p_row) else $error("wrong row or bank");
   property p_col;
      s_rw |-> cmd.col == $past(ca_pin.addr[9:0], 3)
         && cmd.auto_pre == $past(ca_pin.addr[DPC_AP_BIT], 3);
   endproperty
   a_col: assert property (p_col) else $error("wrong column or auto precharge");
   property p_pre;
      s_go(DPC_CMD_PRE) |-> cmd.all_banks == $past(ca_pin.addr[DPC_AP_BIT], 3);
   endproperty
   a_pre: assert property (p_pre) else $error("wrong precharge scope");
   property p_open;
      s_go(DPC_CMD_ACT) |=> bank_open[$past(cmd.bank)];
   endproperty
   a_open: assert property (p_open) else $error("activated bank not open");
   property p_close;
      s_go(DPC_CMD_PRE) ##0 cmd.all_banks |=> bank_open == '0;
   endproperty
   a_close: assert property (p_close) else $error("banks left open");
   property p_pd_buf;
      pwr_state inside {DPC_PWR_PRE_PD, DPC_PWR_ACT_PD} |-> buf_en == 5'h1C;
   endproperty
   a_pd_buf: assert property (p_pd_buf) else $error("power-down buffers wrong");
   property p_sr_buf;
      pwr_state == DPC_PWR_SELF_REF |-> buf_en == 5'h08;
   endproperty
   a_sr_buf: assert property (p_sr_buf) else $error("self refresh buffers wrong");
   property p_core;
      core_en |-> pwr_state == DPC_PWR_ACTIVE && rd_ready;
   endproperty
   a_core: assert property (p_core) else $error("core on while powered down");
endmodule
bind dpc_pin_cmd dpc_pin_cmd_chk i_chk (.*);

// ==== sim/dpc_ctrl.sv ====
`timescale 1ns/1ps
module dpc_ctrl
   import dpc_pkg::*;
(
   input wire logic clk_sys,
   output dpc_ca_type ca_pin,
   output logic [7:0] dq_in,
   output logic dqs_in,
   output logic dm_in
);
   initial begin
      ca_pin = {1'b1, DPC_CMD_NOP, 3'h0, 16'h0000, 1'b0};
      dq_in = 8'h00;
      dqs_in = 1'b0;
      dm_in = 1'b0;
   end
   // address and bank are inverted after the command so stale values never match
   task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b,
      input logic [15:0] a);
      @(posedge clk_sys);
      ca_pin <= {k, c, b, a, ca_pin.odt};
      @(posedge clk_sys);
      ca_pin <= {k, DPC_CMD_NOP, ~b, ~a, ca_pin.odt};
   endtask
   task automatic beat(input logic [7:0] d, input logic m);
      @(posedge clk_sys);
      dq_in <= d;
      dm_in <= m;
      @(posedge clk_sys);
      dqs_in <= ~dqs_in;
      repeat (2) @(posedge clk_sys);
      dq_in <= ~d;
      dm_in <= ~m;
   endtask
   task automatic pin(input logic k, input logic o);
      @(posedge clk_sys);
      ca_pin.cke <= k;
      ca_pin.odt <= o;
   endtask
endmodule

// ==== sim/dpc_pin_cmd_tb.sv ====
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
   $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module dpc_pin_cmd_tb
   import dpc_pkg::*;
;
   typedef struct packed {
      logic [3:0] c;
      logic [2:0] b;
      logic [15:0] a;
      logic v;
      logic [7:0] bo;
   } dpc_row_type;
   logic clk_sys = 1'b0, reset = 1'b1, reset_n = 1'b1, rd_valid = 1'b0, d0, clk_en = 1'b1;
   logic [7:0] rd_data = 8'h00, dq_in, dq_out, wr_data, bank_open, lw;
   logic dqs_in, dm_in, dq_oe_n, dqs_out, dqs_oe_n, rd_ready, core_en, wr_valid, wr_busy;
   logic term_dq, term_dqs, term_dm, tdqs_active, tdqs_n_active;
   dpc_ca_type ca_pin;
   dpc_dec_type cmd, last;
   dpc_pwr_type pwr_state;
   dpc_buf_type buf_en;
   int fails = 0, num_checks = 0, ncmd = 0, nwr = 0, n0;
   dpc_row_type rows [11] = '{
      '{DPC_CMD_MRS, 3'h0, 16'h0001, 1'b1, 8'h00}, '{DPC_CMD_MRS, 3'h1, 16'h0004, 1'b1, 8'h00},
      '{DPC_CMD_MRS, 3'h4, 16'h0000, 1'b1, 8'h00}, '{DPC_CMD_ACT, 3'h3, 16'h1234, 1'b1, 8'h08},
      '{4'hB, 3'h6, 16'h0000, 1'b0, 8'h08}, '{DPC_CMD_RD, 3'h3, 16'h0455, 1'b1, 8'h00},
      '{DPC_CMD_ACT, 3'h1, 16'hBEEF, 1'b1, 8'h02}, '{DPC_CMD_ACT, 3'h6, 16'h0001, 1'b1, 8'h42},
      '{DPC_CMD_PRE, 3'h1, 16'h0000, 1'b1, 8'h40}, '{DPC_CMD_PRE, 3'h2, 16'h0400, 1'b1, 8'h00},
      '{DPC_CMD_NOP, 3'h0, 16'h0000, 1'b0, 8'h00}};
   always #4 clk_sys = ~clk_sys;
   dpc_pin_cmd i_dut (.*);
   dpc_ctrl i_ctrl (.*);
   always @(posedge clk_sys) begin
      if (cmd.valid === 1'b1) begin
         ncmd++;
         last = cmd;
      end
      if (wr_valid === 1'b1) begin
         nwr++;
         lw = wr_data;
      end
   end
   task automatic w(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   task automatic cm(input logic [3:0] c, input logic [2:0] b, input logic [15:0] a);
      i_ctrl.issue(1'b1, c, b, a);
      w(4);
   endtask
   task automatic wr(input logic [15:0] a, input int nb, input logic [7:0] m, input int e);
      n0 = nwr;
      cm(DPC_CMD_WR, 3'h0, a);
      `CHK(wr_busy, 1'b1)
      for (int i = 0; i < nb; i++) i_ctrl.beat(8'(i + 1), m[i]);
      w(6);
      `CHK(nwr - n0, e)
      `CHK(lw, 8'(e + (m != 8'h00 && !tdqs_active)))
   endtask
   task automatic results();
      $display("checks %0d fails %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      fails++;
      results();
   end
   initial begin
      repeat (20) @(posedge clk_sys);
      reset <= 1'b0;
      w(1);
      `CHK({bank_open, pwr_state, dq_oe_n}, 11'h001)
      for (int i = 0; i < 11; i++) begin
         n0 = ncmd;
         cm(rows[i].c, rows[i].b, rows[i].a);
         `CHK(ncmd - n0 == 1, rows[i].v)
         if (rows[i].v) `CHK({last.kind, last.bank}, {rows[i].c, rows[i].b})
         `CHK(bank_open, rows[i].bo)
      end
      $display("command rows done");
      cm(DPC_CMD_ACT, 3'h0, 16'h0000);
      wr(16'h1000, 8, 8'h04, 7);
      wr(16'h0000, 5, 8'h00, 4);
      cm(DPC_CMD_MRS, 3'h1, 16'h0804);
      `CHK({tdqs_active, tdqs_n_active}, 2'h3)
      wr(16'h0000, 4, 8'h0F, 4);
      cm(DPC_CMD_MRS, 3'h1, 16'h0004);
      $display("write tests done");
      i_ctrl.pin(1'b1, 1'b1);
      w(5);
      `CHK({term_dq, term_dqs, term_dm}, 3'h7)
      i_ctrl.pin(1'b1, 1'b0);
      w(5);
      `CHK({term_dq, term_dqs, term_dm}, 3'h0)
      cm(DPC_CMD_MRS, 3'h1, 16'h0000);
      i_ctrl.pin(1'b1, 1'b1);
      w(5);
      `CHK(term_dq, 1'b0)
      $display("termination tests done");
      d0 = dqs_out;
      @(posedge clk_sys);
      rd_valid <= 1'b1;
      rd_data <= 8'hA5;
      @(posedge clk_sys);
      rd_valid <= 1'b0;
      rd_data <= 8'h5A;
      #1;
      `CHK({dq_out, dq_oe_n, dqs_oe_n, dqs_out}, {8'hA5, 2'h0, ~d0})
      $display("read test done");
      cm(DPC_CMD_PRE, 3'h0, 16'h0400);
      i_ctrl.pin(1'b0, 1'b0);
      w(6);
      `CHK(pwr_state, DPC_PWR_PRE_PD)
      n0 = ncmd;
      i_ctrl.issue(1'b0, DPC_CMD_ACT, 3'h5, 16'h0000);
      w(5);
      `CHK(ncmd, n0)
      i_ctrl.pin(1'b1, 1'b0);
      w(6);
      `CHK(pwr_state, DPC_PWR_ACTIVE)
      cm(DPC_CMD_ACT, 3'h2, 16'h0000);
      i_ctrl.pin(1'b0, 1'b0);
      w(6);
      `CHK(pwr_state, DPC_PWR_ACT_PD)
      i_ctrl.pin(1'b1, 1'b0);
      w(6);
      cm(DPC_CMD_PRE, 3'h0, 16'h0400);
      i_ctrl.issue(1'b0, DPC_CMD_REF, 3'h0, 16'h0000);
      w(6);
      `CHK({pwr_state, rd_ready, core_en}, {DPC_PWR_SELF_REF, 2'h0})
      i_ctrl.pin(1'b1, 1'b0);
      w(6);
      `CHK(pwr_state, DPC_PWR_ACTIVE)
      $display("power tests done");
      // a frozen block must lose a command offered while the enable is low
      @(posedge clk_sys);
      clk_en <= 1'b0;
      n0 = ncmd;
      cm(DPC_CMD_ACT, 3'h4, 16'h0000);
      `CHK(ncmd, n0)
      `CHK(bank_open, 8'h00)
      @(posedge clk_sys);
      clk_en <= 1'b1;
      w(3);
      $display("clock enable test done");
      cm(DPC_CMD_ACT, 3'h7, 16'h0000);
      #3 reset_n = 1'b0;
      #1;
      `CHK(bank_open, 8'h00)
      #2 reset_n = 1'b1;
      w(2);
      `CHK(pwr_state, DPC_PWR_ACTIVE)
      $display("pin reset test done");
      results();
   end
endmodule
